// File: rtl/ssp_parser.sv
// Segment stream parser: walks segments of each message, keeps context
`timescale 1ns/1ps
`default_nettype none
module ssp_parser (
    input  wire logic                    mclk_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    in_valid_i,
    input  wire ssp_pkg::ssp_in_beat_s   in_beat_i,
    input  wire logic [31:0]             msg_len_i,
    input  wire logic [95:0]             local_prefix_i,
    output logic                         in_ready_o,
    output logic                         seg_valid_o,
    output ssp_pkg::ssp_seg_beat_s       seg_beat_o,
    input  wire logic                    seg_ready_i,
    output ssp_pkg::ssp_ctx_s            ctx_o,
    output logic                         msg_invalid_o,
    output logic                         msg_done_o,
    output logic                         skip_o
);
    typedef enum logic [1:0] {ST_HDR, ST_SHDR, ST_BODY, ST_DROP} ssp_state_e;

    typedef struct packed {
        ssp_state_e             st;
        logic [15:0]            pos;
        logic [31:0]            rem;
        logic [7:0]             kind;
        logic [7:0]             flags;
        logic [15:0]            slen;
        logic [31:0]            left;
        logic                   fwd;
        logic                   ctxk;
        logic [31:0]            word;
        logic [31:0]            stg_a;
        logic [31:0]            stg_b;
        logic [95:0]            stg_prefix;
        ssp_pkg::ssp_ctx_s      ctx;
        logic                   bad;
        logic                   ready;
        logic                   done;
        logic                   skip;
        logic                   wr;
        ssp_pkg::ssp_seg_beat_s wbeat;
    } ssp_regs_s;

    ssp_regs_s  r_reg;
    ssp_regs_s  r_next;
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [5:0] fifo_level;
    logic       take;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    assign take = in_valid_i && r_reg.ready;

    always_comb
    begin
        ssp_state_e  st;
        logic [15:0] pos;
        logic [31:0] rem_now;
        logic [31:0] ra;
        logic [7:0]  b;
        logic [31:0] wd;
        logic [15:0] lenv;
        logic [15:0] so;
        logic        inval;
        logic        little;
        st      = r_reg.st;
        pos     = r_reg.pos;
        rem_now = r_reg.rem;
        b       = in_beat_i.data;
        inval   = 1'b0;
        lenv    = 16'h0000;
        so      = ssp_pkg::set_off(r_reg.kind);
        little  = r_reg.flags[ssp_pkg::FLAG_ORDER];
        r_next  = r_reg;
        r_next.done  = 1'b0;
        r_next.skip  = 1'b0;
        r_next.wr    = 1'b0;
        r_next.ready = fifo_level <= 6'(ssp_pkg::FIFO_DEPTH - ssp_pkg::READY_SLACK);
        if (take && in_beat_i.first)  // Fresh context for every message
        begin
            st      = ST_HDR;
            pos     = 16'h0000;
            rem_now = msg_len_i;
            r_next.bad = 1'b0;
            r_next.ctx = '{src_version: ssp_pkg::VER_2_1, src_impl: ssp_pkg::IMPL_UNSET,
                           src_prefix: '0, dst_prefix: local_prefix_i,
                           answer_seen: 1'b0, have_time: 1'b0, time_value: '0};
        end
        ra = rem_now - 32'h0000_0001;
        wd = (st == ST_BODY && little) ? {b, r_reg.word[31:8]} : {r_reg.word[23:0], b};
        if (take)
        begin
            r_next.rem  = ra;
            r_next.word = wd;
            r_next.pos  = pos + 16'h0001;
            unique case (st)
                ST_HDR:
                begin
                    if (pos == 16'h0003 && wd != ssp_pkg::PROTO_TAG)
                        inval = 1'b1;
                    if (pos == 16'h0004 && b > ssp_pkg::MAJOR_MAX)
                        inval = 1'b1;
                    if (pos >= 16'h0004 && pos < 16'h0008)
                        r_next.stg_a = {r_reg.stg_a[23:0], b};
                    if (pos >= 16'h0008)
                        r_next.stg_prefix = {r_reg.stg_prefix[87:0], b};
                    if (pos == 16'(ssp_pkg::HDR_LEN - 1))
                    begin
                        // Valid header loads version, implementer and prefix
                        r_next.ctx.src_version = r_reg.stg_a[31:16];
                        r_next.ctx.src_impl    = r_reg.stg_a[15:0];
                        r_next.ctx.src_prefix  = {r_reg.stg_prefix[87:0], b};
                        r_next.st  = ST_SHDR;
                        r_next.pos = 16'h0000;
                    end
                end
                ST_SHDR:
                begin
                    if (pos == 16'h0000 && rem_now < 32'(ssp_pkg::SUBHDR_LEN))
                        inval = 1'b1;
                    if (pos == 16'h0000)
                        r_next.kind = b;
                    if (pos == 16'h0001)
                        r_next.flags = b;  // Order and no-time bits used, rest ignored
                    if (pos == 16'h0002)
                        r_next.slen = {8'h00, b};
                    if (pos == 16'h0003)
                    begin
                        lenv = little ? {b, r_reg.slen[7:0]} : {r_reg.slen[7:0], b};
                        r_next.slen = lenv;
                        if (lenv == 16'h0000)
                            r_next.left = ra;
                        else if (32'(lenv) > ra)
                            inval = 1'b1;
                        else
                            r_next.left = 32'(lenv);
                        if (ssp_pkg::min_len(r_reg.kind, r_reg.flags) > r_next.left)
                            inval = 1'b1;
                        r_next.fwd  = ssp_pkg::is_endpoint(r_reg.kind);
                        r_next.ctxk = ssp_pkg::is_context(r_reg.kind);
                        // Vendor kinds and undefined kinds are walked over
                        r_next.skip = !ssp_pkg::is_known(r_reg.kind)
                                      || (r_reg.kind >= ssp_pkg::K_VENDOR_MIN
                                          && r_reg.ctx.src_impl == ssp_pkg::IMPL_UNSET);
                        r_next.pos = 16'h0000;
                        r_next.st  = (r_next.left == 32'h0000_0000) ? ST_SHDR : ST_BODY;
                    end
                end
                ST_BODY:
                begin
                    r_next.left = r_reg.left - 32'h0000_0001;
                    if (r_reg.kind == ssp_pkg::K_ORIGIN && pos >= 16'h0004 && pos < 16'h0008)
                        r_next.stg_a = {r_reg.stg_a[23:0], b};
                    if ((r_reg.kind == ssp_pkg::K_ORIGIN && pos >= 16'h0008)
                        || r_reg.kind == ssp_pkg::K_TARGET)
                        r_next.stg_prefix = {r_reg.stg_prefix[87:0], b};
                    if ((r_reg.kind == ssp_pkg::K_TIME || so != 16'h0000)
                        && pos == so + 16'h0003)
                        r_next.stg_a = wd;
                    if ((r_reg.kind == ssp_pkg::K_TIME || so != 16'h0000)
                        && pos == so + 16'h0007)
                        r_next.stg_b = wd;
                    // Signed 64-bit base, span within 256, unset index refused
                    if (so != 16'h0000 && pos == so + 16'h000B
                        && !ssp_pkg::seq_set_ok(r_reg.stg_a, r_reg.stg_b, wd))
                        inval = 1'b1;
                    if ((r_reg.kind == ssp_pkg::K_PIECE || r_reg.kind == ssp_pkg::K_KL_PIECE)
                        && pos == 16'h0013 && wd == 32'h0000_0000)
                        inval = 1'b1;  // Unsigned piece number, zero refused
                    if (r_reg.left == 32'h0000_0001)
                    begin
                        if (r_reg.ctxk && !inval)
                        begin
                            unique case (r_reg.kind)
                                ssp_pkg::K_ORIGIN:
                                begin
                                    r_next.ctx.src_version = r_reg.stg_a[31:16];
                                    r_next.ctx.src_impl    = r_reg.stg_a[15:0];
                                    r_next.ctx.src_prefix  = r_reg.stg_prefix;
                                end
                                ssp_pkg::K_TARGET:
                                    r_next.ctx.dst_prefix = {r_reg.stg_prefix[87:0], b};
                                ssp_pkg::K_TIME:
                                begin
                                    r_next.ctx.have_time  = !r_reg.flags[ssp_pkg::FLAG_NO_TIME];
                                    r_next.ctx.time_value = {r_reg.stg_a, r_reg.stg_b};
                                end
                                default:
                                    r_next.ctx.answer_seen = 1'b1;
                            endcase
                        end
                        r_next.st  = ST_SHDR;
                        r_next.pos = 16'h0000;
                    end
                    if (r_reg.fwd)
                    begin
                        r_next.wr    = 1'b1;
                        r_next.wbeat = '{data: b, kind: r_reg.kind, first: pos == 16'h0000,
                                         last: r_reg.left == 32'h0000_0001 || inval
                                               || in_beat_i.last,
                                         bad: inval || (in_beat_i.last
                                                        && r_reg.left != 32'h0000_0001),
                                         little: little};
                    end
                end
                default:
                    r_next.st = ST_DROP;
            endcase
            if (in_beat_i.last && (st == ST_HDR || (st == ST_SHDR && pos != 16'h0003)
                || (st == ST_BODY && r_reg.left != 32'h0000_0001)))
                inval = 1'b1;
            if (inval)
            begin
                r_next.st  = ST_DROP;
                r_next.bad = 1'b1;
            end
            if (in_beat_i.last)
            begin
                r_next.done = 1'b1;
                r_next.st   = ST_HDR;
                r_next.pos  = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    ssp_fifo #(
        .W     ($bits(ssp_pkg::ssp_seg_beat_s)),
        .DEPTH (ssp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n),
        .wr_valid_i (r_reg.wr),
        .wr_data_i  (r_reg.wbeat),
        .wr_ready_o (),
        .rd_valid_o (seg_valid_o),
        .rd_data_o  (seg_beat_o),
        .rd_ready_i (seg_ready_i),
        .level_o    (fifo_level)
    );

    assign in_ready_o    = r_reg.ready;
    assign ctx_o         = r_reg.ctx;
    assign msg_invalid_o = r_reg.bad;
    assign msg_done_o    = r_reg.done;
    assign skip_o        = r_reg.skip;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    property p_short_tail;
        take && !in_beat_i.first && r_reg.st == ST_SHDR && r_reg.pos == 16'h0000
        && r_reg.rem < 32'h0000_0004 |=> r_reg.bad;
    endproperty
    a_short_tail: assert property (p_short_tail) else $error("short tail not flagged");

    property p_len_over;
        take && r_reg.st == ST_SHDR && r_reg.pos == 16'h0003 && r_next.slen != 16'h0000
        && 32'(r_next.slen) > r_reg.rem - 32'h0000_0001 |=> r_reg.bad && r_reg.st != ST_BODY;
    endproperty
    a_len_over: assert property (p_len_over) else $error("oversize length accepted");

    property p_zero_len;
        take && !in_beat_i.last && r_reg.st == ST_SHDR && r_reg.pos == 16'h0003
        && r_next.slen == 16'h0000 && !r_reg.bad |=> r_reg.left == $past(r_reg.rem) - 32'h0000_0001;
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length not to end");

    property p_bad_holds;
        r_reg.bad && !(take && in_beat_i.first) |=> r_reg.bad;
    endproperty
    a_bad_holds: assert property (p_bad_holds) else $error("invalid flag dropped");

    property p_no_fwd_bad;
        r_reg.bad && !r_reg.wr |=> !r_reg.wr;
    endproperty
    a_no_fwd_bad: assert property (p_no_fwd_bad) else $error("forwarding after invalid");

    property p_fwd_kind;
        r_reg.wr |-> ssp_pkg::is_endpoint(r_reg.wbeat.kind);
    endproperty
    a_fwd_kind: assert property (p_fwd_kind) else $error("non endpoint kind forwarded");

    property p_ctx_still;
        take && !in_beat_i.first && r_reg.st == ST_BODY && !r_reg.ctxk |=> $stable(r_reg.ctx);
    endproperty
    a_ctx_still: assert property (p_ctx_still) else $error("context changed by other kind");

    property p_ctx_init;
        take && in_beat_i.first |=> !r_reg.ctx.have_time && r_reg.ctx.src_impl == ssp_pkg::IMPL_UNSET;
    endproperty
    a_ctx_init: assert property (p_ctx_init) else $error("context not reinitialised");

    property p_set_check;
        take && r_reg.st == ST_BODY && ssp_pkg::set_off(r_reg.kind) != 16'h0000
        && r_reg.pos == ssp_pkg::set_off(r_reg.kind) + 16'h000B
        && !ssp_pkg::seq_set_ok(r_reg.stg_a, r_reg.stg_b, r_next.word) |=> r_reg.bad;
    endproperty
    a_set_check: assert property (p_set_check) else $error("bad bitmap accepted");
endmodule
`default_nettype wire

// File: rtl/ssp_pkg.sv
// Shared constants, types and checks for the segment stream parser
package ssp_pkg;

    localparam int          HDR_LEN      = 20;
    localparam int          SUBHDR_LEN   = 4;
    localparam int          FIFO_DEPTH   = 32;
    localparam int          READY_SLACK  = 4;
    localparam logic [31:0] PROTO_TAG    = 32'h5254_5053;
    localparam logic [7:0]  MAJOR_MAX    = 8'h02;
    localparam logic [15:0] VER_1_0      = 16'h0100;
    localparam logic [15:0] VER_1_1      = 16'h0101;
    localparam logic [15:0] VER_2_0      = 16'h0200;
    localparam logic [15:0] VER_2_1      = 16'h0201;
    localparam logic [15:0] IMPL_UNSET   = 16'h0000;
    localparam logic [31:0] SEQ_UNSET_HI = 32'hFFFF_FFFF;
    localparam logic [31:0] SEQ_UNSET_LO = 32'h0000_0000;
    localparam logic [31:0] SET_SPAN     = 32'h0000_0100;
    localparam int          FLAG_ORDER   = 0;
    localparam int          FLAG_NO_TIME = 1;

    localparam logic [7:0] K_PAD        = 8'h01;
    localparam logic [7:0] K_RECEIPT    = 8'h06;
    localparam logic [7:0] K_AVAIL      = 8'h07;
    localparam logic [7:0] K_GAP        = 8'h08;
    localparam logic [7:0] K_TIME       = 8'h09;
    localparam logic [7:0] K_KEYLESS    = 8'h0A;
    localparam logic [7:0] K_KL_PIECE   = 8'h0B;
    localparam logic [7:0] K_ORIGIN     = 8'h0C;
    localparam logic [7:0] K_ANSWER_IP4 = 8'h0D;
    localparam logic [7:0] K_TARGET     = 8'h0E;
    localparam logic [7:0] K_ANSWER     = 8'h0F;
    localparam logic [7:0] K_MISSING    = 8'h12;
    localparam logic [7:0] K_PIECE_AV   = 8'h13;
    localparam logic [7:0] K_PAYLOAD    = 8'h15;
    localparam logic [7:0] K_PIECE      = 8'h16;
    localparam logic [7:0] K_VENDOR_MIN = 8'h80;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
    } ssp_in_beat_s;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] kind;
        logic       first;
        logic       last;
        logic       bad;
        logic       little;
    } ssp_seg_beat_s;

    typedef struct packed {
        logic [15:0] src_version;
        logic [15:0] src_impl;
        logic [95:0] src_prefix;
        logic [95:0] dst_prefix;
        logic        answer_seen;
        logic        have_time;
        logic [63:0] time_value;
    } ssp_ctx_s;

    function automatic logic is_endpoint(input logic [7:0] k);
        return k inside {K_PAYLOAD, K_KEYLESS, K_PIECE, K_KL_PIECE, K_AVAIL,
                         K_RECEIPT, K_GAP, K_PIECE_AV, K_MISSING};
    endfunction

    function automatic logic is_context(input logic [7:0] k);
        return k inside {K_ORIGIN, K_ANSWER, K_TARGET, K_TIME};
    endfunction

    function automatic logic is_known(input logic [7:0] k);
        return is_endpoint(k) || is_context(k) || k == K_PAD || k == K_ANSWER_IP4;
    endfunction

    // Least body length of each known kind
    function automatic logic [31:0] min_len(input logic [7:0] k, input logic [7:0] f);
        unique case (k)
            K_RECEIPT:              return 32'h0000_0018;
            K_AVAIL, K_GAP:         return 32'h0000_001C;
            K_MISSING, K_PIECE_AV:  return 32'h0000_0014;
            K_PAYLOAD, K_KEYLESS:   return 32'h0000_0010;
            K_PIECE, K_KL_PIECE:    return 32'h0000_0014;
            K_ORIGIN:               return 32'h0000_0014;
            K_TARGET:               return 32'h0000_000C;
            K_TIME:                 return f[FLAG_NO_TIME] ? 32'h0000_0000 : 32'h0000_0008;
            default:                return 32'h0000_0000;
        endcase
    endfunction

    // Body offset of the sample index bitmap base, zero when none
    function automatic logic [15:0] set_off(input logic [7:0] k);
        unique case (k)
            K_RECEIPT: return 16'h0008;
            K_GAP:     return 16'h0010;
            default:   return 16'h0000;
        endcase
    endfunction

    function automatic logic seq_set_ok(input logic [31:0] hi, input logic [31:0] lo,
                                        input logic [31:0] nbits);
        logic signed [63:0] base;
        base = signed'({hi, lo});
        return (base >= 64'sd1) && (nbits <= SET_SPAN)
               && !({hi, lo} == {SEQ_UNSET_HI, SEQ_UNSET_LO});
    endfunction

endpackage

// File: rtl/ssp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wr_valid_i,
    input  wire logic [W-1:0]           wr_data_i,
    output logic                        wr_ready_o,
    output logic                        rd_valid_o,
    output logic [W-1:0]                rd_data_o,
    input  wire logic                   rd_ready_i,
    output logic [$clog2(DEPTH):0]      level_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
    } ssp_fifo_s;

    ssp_fifo_s      r_reg;
    ssp_fifo_s      r_next;
    logic [W-1:0]   mem [DEPTH];
    logic           push;
    logic           pop;

    assign wr_ready_o = r_reg.count != (AW+1)'(DEPTH);
    assign rd_valid_o = r_reg.count != '0;
    assign rd_data_o  = mem[r_reg.rptr];
    assign level_o    = r_reg.count;
    assign push       = wr_valid_i && wr_ready_o;
    assign pop        = rd_valid_o && rd_ready_i;

    always_comb
    begin
        r_next = r_reg;
        if (push)
            r_next.wptr = r_reg.wptr + 1'b1;
        if (pop)
            r_next.rptr = r_reg.rptr + 1'b1;
        r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    always_ff @(posedge mclk_i)
    begin
        if (push)
            mem[r_reg.wptr] <= wr_data_i;
    end
endmodule
`default_nettype wire

// File: tb/ssp_xport.sv
// Transport model: hands whole messages to the parser byte by byte
`timescale 1ns/1ps
`default_nettype none
module ssp_xport (
    input  wire logic             mclk_i,
    input  wire logic             ready_i,
    output logic                  valid_o,
    output ssp_pkg::ssp_in_beat_s beat_o,
    output logic [31:0]           len_o
);
    initial
    begin
        valid_o = 1'b0;
        beat_o = '0;
        len_o = '0;
    end

    // Each byte held until ready is seen at a take edge
    task automatic send(input logic [7:0] m[$]);
        for (int i = 0; i < m.size(); i++)
        begin
            valid_o = 1'b1;
            len_o = 32'(m.size());
            beat_o = '{data: m[i], first: i == 0, last: i == m.size() - 1};
            @(negedge mclk_i);
            while (ready_i !== 1'b1)
                @(negedge mclk_i);
            @(posedge mclk_i);
            #1;
        end
        // Released lines show inverted data, not the last byte
        valid_o = 1'b0;
        beat_o.data = ~beat_o.data;
        len_o = ~len_o;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_submessage_stream_parser.sv
// Testbench: parser against a queue model of forwarded segment bytes
`timescale 1ns/1ps
`default_nettype none
module tb_submessage_stream_parser;
    logic                   mclk_i = 1'b0;
    logic                   arst_n_i = 1'b0;
    logic                   seg_ready_i = 1'b0;
    logic                   in_valid_i;
    logic                   in_ready_o;
    logic                   seg_valid_o;
    logic                   msg_invalid_o;
    logic                   msg_done_o;
    logic                   skip_o;
    logic [31:0]            msg_len_i;
    logic [95:0]            prefix = '0;
    logic [95:0]            hp;
    ssp_pkg::ssp_in_beat_s  in_beat_i;
    ssp_pkg::ssp_seg_beat_s seg_beat_o;
    ssp_pkg::ssp_ctx_s      ctx_o;
    ssp_pkg::ssp_seg_beat_s exp[$];
    logic [7:0]             m[$];
    int                     bad_count = 0;
    int                     check_count = 0;
    int                     skips = 0;

    ssp_parser DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .in_valid_i(in_valid_i),
        .in_beat_i(in_beat_i), .msg_len_i(msg_len_i), .local_prefix_i(prefix),
        .in_ready_o(in_ready_o), .seg_valid_o(seg_valid_o), .seg_beat_o(seg_beat_o),
        .seg_ready_i(seg_ready_i), .ctx_o(ctx_o), .msg_invalid_o(msg_invalid_o),
        .msg_done_o(msg_done_o), .skip_o(skip_o));
    ssp_xport xp (.mclk_i(mclk_i), .ready_i(in_ready_o), .valid_o(in_valid_i),
        .beat_o(in_beat_i), .len_o(msg_len_i));

    initial
    begin
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [95:0] got, input logic [95:0] want);
        check_count++;
        if (got !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, want);
        end
    endtask

    task automatic check_beat();
        ssp_pkg::ssp_seg_beat_s want;
        want = exp.size() ? exp.pop_front() : ~seg_beat_o;
        check(96'(seg_beat_o), 96'(want));
    endtask

    task automatic hdr(input bit tag_ok);
        hp = {$urandom(), $urandom(), $urandom()};
        m = '{8'h52, 8'h54, 8'h50, tag_ok ? 8'h53 : 8'h54, 8'h02, 8'h01, 8'h01, 8'h02};
        for (int i = 11; i >= 0; i--)
            m.push_back(hp[i*8+:8]);
    endtask

    task automatic seg(input logic [7:0] k, input logic [7:0] f, input logic [15:0] len,
                       input int n, input bit fwd);
        logic [7:0] d;
        m.push_back(k);
        m.push_back(f);
        m.push_back(f[0] ? len[7:0] : len[15:8]);
        m.push_back(f[0] ? len[15:8] : len[7:0]);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom());
            m.push_back(d);
            if (fwd)
                exp.push_back('{data: d, kind: k, first: i == 0, last: i == n - 1,
                                bad: 1'b0, little: f[0]});
        end
    endtask

    // Big endian segment: 16 random bytes, three words; bytes up to cut expected
    task automatic elem(input logic [7:0] k, input logic [95:0] w, input int cut,
                        input bit ok);
        logic [7:0] d;
        m.push_back(k);
        m.push_back(8'h00);
        m.push_back(8'h00);
        m.push_back(8'h1C);
        for (int i = 0; i < 28; i++)
        begin
            d = (i < 16) ? 8'($urandom()) : w[8 * (27 - i) +: 8];
            m.push_back(d);
            if (i <= cut)
                exp.push_back('{data: d, kind: k, first: i == 0, last: i == cut,
                                bad: !ok && i == cut, little: 1'b0});
        end
    endtask

    // Sends the message, waits for its end and for the output to drain
    task automatic run(input bit inv, input int nskip);
        int t;
        skips = 0;
        xp.send(m);
        for (t = 0; t < 100 && msg_done_o !== 1'b1; t++)
            @(negedge mclk_i);
        check(96'(msg_done_o), 96'(1));
        for (t = 0; t < 200 && exp.size() != 0; t++)
            @(negedge mclk_i);
        repeat (8) @(negedge mclk_i);
        check(96'(msg_invalid_o), 96'(inv));
        check(96'(exp.size()), 96'(0));
        if (nskip >= 0)
            check(96'(skips), 96'(nskip));
        @(posedge mclk_i);
        #1;
    endtask

    always @(posedge mclk_i)
        seg_ready_i <= #1 ($urandom() % 4) != 0;

    always @(negedge mclk_i)
    begin
        if (skip_o === 1'b1)
            skips++;
        if (seg_valid_o === 1'b1 && seg_ready_i)
            check_beat();
    end

    initial
    begin
        #100000;
        bad_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(59981));
        repeat (10) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            prefix = {$urandom(), $urandom(), $urandom()};
            hdr(1'b1);
            seg(8'h30, 8'h00, 16'h0004, 4, 1'b0);
            seg(ssp_pkg::K_VENDOR_MIN, 8'hFE, 16'h0004, 4, 1'b0);
            seg(ssp_pkg::K_PAYLOAD, 8'h01, 16'h0014, 20, 1'b1);
            seg(ssp_pkg::K_PAYLOAD, 8'h00, 16'h0000, 16, 1'b1);
            run(1'b0, 2);
            check(ctx_o.dst_prefix, prefix);
            check(ctx_o.src_prefix, hp);
            check(96'(ctx_o.src_version), 96'(ssp_pkg::VER_2_1));
            hdr(1'b1);
            seg(8'h30, 8'h00, 16'h0004, 4, 1'b0);
            m.push_back(8'h15);
            m.push_back(8'h00);
            run(1'b1, -1);
            hdr(1'b1);
            seg(8'h30, 8'h00, 16'h00C8, 4, 1'b0);
            run(1'b1, -1);
            hdr(1'b0);
            seg(ssp_pkg::K_PAYLOAD, 8'h00, 16'h0010, 16, 1'b0);
            run(1'b1, -1);
            check(96'(ctx_o.src_impl), 96'(ssp_pkg::IMPL_UNSET));
            hdr(1'b1);
            elem(ssp_pkg::K_GAP, {32'h0000_0000, 32'($urandom()) | 32'h0000_0001,
                 r ? 32'h0000_0100 : 32'h0000_0008}, 27, 1'b1);
            elem(ssp_pkg::K_PIECE, {32'h0000_0001, $urandom(), $urandom()},
                 27, 1'b1);
            run(1'b0, 0);
            hdr(1'b1);
            elem(ssp_pkg::K_GAP, {r ? 64'hFFFF_FFFF_0000_0000 : 64'h0000_0000_0000_0001,
                 r ? 32'h0000_0008 : 32'h0000_0101}, 27, 1'b0);
            run(1'b1, -1);
            hdr(1'b1);
            elem(ssp_pkg::K_PIECE, {32'h0000_0000, $urandom(), $urandom()},
                 19, 1'b0);
            run(1'b1, -1);
        end
        final_report();
    end
endmodule
`default_nettype wire
